//--- sid_status_top.sv
`timescale 1ns/1ps
module sid_status_top
  import sid_pkg::*;
#(
  parameter int          TICK_CYC_P  = TICK_CYC,
  parameter logic [11:0] BLINK_MS_P  = BLINK_MS,
  parameter logic [11:0] SLOW_MS_P   = SLOW_MS,
  parameter logic [11:0] FAST_MS_P   = FAST_MS,
  parameter logic [27:0] GLY_ESTOP_P = GLY_ESTOP,
  parameter logic [27:0] GLY_DOOR_P  = GLY_DOOR,
  parameter logic [27:0] GLY_READY_P = GLY_READY
) (
  // Clock and reset.
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // Wishbone slave.
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Control unit indicators.
  output logic      [3:0]  mode_led,
  output logic      [27:0] seg_out,
  // Drive unit indicators.
  output logic             du_run_led,
  output logic             du_auto_led,
  output logic             du_err_led,
  output logic             du_link_led,
  // Interrupt.
  output logic             irq
);
  sid_du_if du ();

  logic [15:0] tick_cnt_q;
  logic        tick_q;
  logic        wr;
  logic        rd;
  logic [5:0]  widx;
  logic [31:0] ctrl_q;
  logic [16:0] err_q;
  logic [16:0] warn_q;
  logic [3:0]  task_q;
  logic [11:0] line_q [16];
  logic [11:0] line_sel;
  logic [2:0]  ev;
  logic [2:0]  istat_q;
  logic [2:0]  ien_q;
  logic        msg_on_q;
  logic        msg_fail_q;
  logic [11:0] msg_ms_q;
  logic [11:0] alt_ms_q;
  logic        alt_q;
  logic [11:0] blk_ms_q;
  logic        blink_q;
  sid_show_e   show_d;
  sid_show_e   show_q;
  logic [27:0] seg_d;
  sid_mode_e   mode;

  // Merge written bytes into an old word under the byte selects.
  function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] d,
                                         input logic [3:0] s);
    logic [31:0] m;
    m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    return (o & ~m) | (d & m);
  endfunction : wmerge

  // Four BCD digits to segment patterns.
  function automatic logic [27:0] num4(input logic [15:0] b);
    return {sid_seg7(b[15:12]), sid_seg7(b[11:8]), sid_seg7(b[7:4]), sid_seg7(b[3:0])};
  endfunction : num4

  // Millisecond tick; every timer counts these so the long counts stay narrow.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_q <= 16'h0000;
      tick_q     <= 1'b0;
    end else if (tick_cnt_q >= 16'(TICK_CYC_P - 1)) begin
      tick_cnt_q <= 16'h0000;
      tick_q     <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 16'h0001;
      tick_q     <= 1'b0;
    end
  end

  // Classic Wishbone: one wait state, ack drops in the cycle after it was given.
  assign widx = wb_adr_i[7:2];
  assign wr   = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
  assign rd   = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
    end
  end

  // Status words written by system software.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= CTRL_RST;
      err_q  <= 17'h00000;
      warn_q <= 17'h00000;
    end else if (wr) begin
      if (widx == A_CTRL) begin
        ctrl_q <= wmerge(ctrl_q, wb_dat_i, wb_sel_i);
      end
      if (widx == A_ERR) begin
        err_q <= 17'(wmerge({15'h0000, err_q}, wb_dat_i, wb_sel_i));
      end
      if (widx == A_WARN) begin
        warn_q <= 17'(wmerge({15'h0000, warn_q}, wb_dat_i, wb_sel_i));
      end
    end
  end

  // Task select starts at task 1; any write with the low byte picks a task.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      task_q <= TASK_RST;
    end else if (wr && widx == A_TASK && wb_sel_i[0]) begin
      task_q <= wb_dat_i[3:0];
    end
  end

  // Execution line per task; the word carries its own task index.
  for (genvar gt = 0; gt < 16; gt++) begin : g_line
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        line_q[gt] <= 12'h000;
      end else if (wr && widx == A_LINE && wb_dat_i[LN_TASK +: 4] == 4'(gt)) begin
        line_q[gt] <= wb_dat_i[11:0];
      end
    end
  end
  assign line_sel = line_q[task_q];

  // Backup results arrive as write-only pulses; they also raise events.
  assign ev[IRQ_OK]   = wr && widx == A_BKRES && wb_dat_i[0];
  assign ev[IRQ_FAIL] = wr && widx == A_BKRES && wb_dat_i[1] && !wb_dat_i[0];
  assign ev[IRQ_END]  = msg_on_q && tick_q && msg_ms_q == 12'h000;

  // Result message timer: counts whole ms ticks, then hands back the display.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      msg_on_q   <= 1'b0;
      msg_fail_q <= 1'b0;
      msg_ms_q   <= 12'h000;
    end else if (ev[IRQ_OK] || ev[IRQ_FAIL]) begin
      msg_on_q   <= 1'b1;
      msg_fail_q <= ev[IRQ_FAIL];
      msg_ms_q   <= MSG_MS - 12'h001;
    end else if (msg_on_q && tick_q) begin
      if (msg_ms_q == 12'h000) begin
        msg_on_q <= 1'b0;
      end else begin
        msg_ms_q <= msg_ms_q - 12'h001;
      end
    end
  end

  // Sticky interrupt bits; a new event in the clearing cycle survives.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      istat_q <= 3'h0;
      ien_q   <= 3'h0;
    end else begin
      if (wr && widx == A_ICLR) begin
        istat_q <= (istat_q & ~wb_dat_i[2:0]) | ev;
      end else begin
        istat_q <= istat_q | ev;
      end
      if (wr && widx == A_IEN) begin
        ien_q <= wb_dat_i[2:0];
      end
    end
  end

  // Interrupt level, registered so the pin comes from a flop.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(istat_q & ien_q);
    end
  end

  // Read data is captured with ack; write-only and unmapped words read zero.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (rd) begin
      unique case (widx)
        A_CTRL:  wb_dat_o <= ctrl_q;
        A_ERR:   wb_dat_o <= {15'h0000, err_q};
        A_WARN:  wb_dat_o <= {15'h0000, warn_q};
        A_TASK:  wb_dat_o <= {28'h0000000, task_q};
        A_LINE:  wb_dat_o <= {12'h000, task_q, 4'h0, line_sel};
        A_ISTAT: wb_dat_o <= {29'h00000000, istat_q};
        A_IEN:   wb_dat_o <= {29'h00000000, ien_q};
        A_STAT:  wb_dat_o <= {25'h0000000, show_q, alt_q, blink_q, msg_on_q};
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // Alternation clock; restarts on a status change so the number shows first.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      alt_ms_q <= 12'h000;
      alt_q    <= 1'b0;
    end else if (show_d != show_q) begin
      alt_ms_q <= 12'h000;
      alt_q    <= 1'b0;
    end else if (tick_q) begin
      if (alt_ms_q >= ALT_MS - 12'h001) begin
        alt_ms_q <= 12'h000;
        alt_q    <= ~alt_q;
      end else begin
        alt_ms_q <= alt_ms_q + 12'h001;
      end
    end
  end

  // Free-running blink for the mode LEDs and blinking display states.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      blk_ms_q <= 12'h000;
      blink_q  <= 1'b0;
    end else if (tick_q) begin
      if (blk_ms_q >= BLINK_MS_P - 12'h001) begin
        blk_ms_q <= 12'h000;
        blink_q  <= ~blink_q;
      end else begin
        blk_ms_q <= blk_ms_q + 12'h001;
      end
    end
  end

  // Pick the one status to show; particular shutdown codes outrank the table.
  always_comb begin
    if (!ctrl_q[C_DONE]) begin
      show_d = SH_BLANK;
    end else if (ctrl_q[C_RECOV]) begin
      show_d = SH_RECOV;
    end else if (ctrl_q[C_ACDROP]) begin
      show_d = SH_ACDROP;
    end else if (ctrl_q[C_SWSD]) begin
      show_d = SH_SWSD;
    end else if (ctrl_q[C_BKBUSY]) begin
      show_d = SH_BKBUSY;
    end else if (msg_on_q && !msg_fail_q) begin
      show_d = SH_BKOK;
    end else if (msg_on_q) begin
      show_d = SH_BKFAIL;
    end else if (err_q[NUM_ACT]) begin
      show_d = SH_ERR;
    end else if (warn_q[NUM_ACT]) begin
      show_d = SH_WARN;
    end else if (ctrl_q[C_ESTOP]) begin
      show_d = SH_ESTOP;
    end else if (ctrl_q[C_DOOR]) begin
      show_d = SH_DOOR;
    end else if (ctrl_q[C_READY]) begin
      show_d = SH_READY;
    end else if (ctrl_q[C_RUN]) begin
      show_d = SH_RUN;
    end else if (ctrl_q[C_PAUSE]) begin
      show_d = SH_PAUSE;
    end else begin
      show_d = SH_IDLE;
    end
  end

  // Compose segments for the chosen status.
  always_comb begin
    unique case (show_q)
      SH_RECOV:  seg_d = num4(CODE_RECOV);
      SH_ACDROP: seg_d = num4(CODE_ACDROP);
      SH_SWSD:   seg_d = num4(CODE_SWSD);
      SH_BKBUSY: seg_d = alt_q ? GLY_BKB : GLY_BKA;
      SH_BKOK:   seg_d = GLY_OK;
      SH_BKFAIL: seg_d = GLY_FAIL;
      SH_ERR:    seg_d = alt_q ? GLY_ERR : num4(err_q[15:0]);
      SH_WARN:   seg_d = alt_q ? GLY_WARN : num4(warn_q[15:0]);
      SH_ESTOP:  seg_d = blink_q ? GLY_ESTOP_P : 28'h0000000;
      SH_DOOR:   seg_d = blink_q ? GLY_DOOR_P : 28'h0000000;
      SH_READY:  seg_d = blink_q ? GLY_READY_P : 28'h0000000;
      SH_RUN:    seg_d = blink_q ? {PFX_RUN, 21'(num4({4'h0, line_sel}))} : 28'h0000000;
      SH_PAUSE:  seg_d = blink_q ? {PFX_PAUSE, 21'(num4({4'h0, line_sel}))} : 28'h0000000;
      default:   seg_d = 28'h0000000;
    endcase
  end

  // Display selection and segments; two cycles of latency are invisible to a viewer.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      show_q  <= SH_BLANK;
      seg_out <= 28'h0000000;
    end else begin
      show_q  <= show_d;
      seg_out <= seg_d;
    end
  end

  // Mode LEDs: all blink until startup, then one-hot on the mode.
  assign mode = sid_mode_e'(ctrl_q[C_MODE +: 2]);
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mode_led <= 4'h0;
    end else if (!ctrl_q[C_DONE]) begin
      mode_led <= {4{blink_q}};
    end else begin
      mode_led <= 4'h1 << mode;
    end
  end

  // Drive unit side.
  assign du.tick      = tick_q;
  assign du.st        = sid_du_e'(ctrl_q[C_DUST +: 2]);
  assign du.auto_mode = (mode == MODE_AUTO);
  assign du.robot_err = ctrl_q[C_RERR];
  assign du.estop     = ctrl_q[C_ESTOP];

  sid_drive_unit #(
    .SLOW_MS_P (SLOW_MS_P),
    .FAST_MS_P (FAST_MS_P)
  ) u_du (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .du      (du.drv)
  );

  assign du_run_led  = du.run_led;
  assign du_auto_led = du.auto_led;
  assign du_err_led  = du.err_led;
  assign du_link_led = du.link_led;
endmodule : sid_status_top

//--- sid_pkg.sv
package sid_pkg;
  // Clock and time base.
  localparam int          CLK_HZ      = 50_000_000;
  localparam int          TICK_CYC    = CLK_HZ / 1000;  // Cycles per 1 ms tick.
  localparam int          MSG_TIME_S  = 2;
  localparam real         ALT_TIME_S  = 0.5;
  localparam logic [11:0] MSG_MS      = 12'(MSG_TIME_S * 1000);
  localparam logic [11:0] ALT_MS      = 12'(int'(ALT_TIME_S * 1000.0));
  localparam logic [11:0] BLINK_MS    = 12'h0FA;        // 250 ms blink half period.
  localparam logic [11:0] SLOW_MS     = 12'h1F4;        // 500 ms run LED flash.
  localparam logic [11:0] FAST_MS     = 12'h064;        // 100 ms link LED flash.

  // Register word offsets (byte address bits 7:2).
  localparam logic [5:0] A_CTRL  = 6'h00;
  localparam logic [5:0] A_ERR   = 6'h01;
  localparam logic [5:0] A_WARN  = 6'h02;
  localparam logic [5:0] A_TASK  = 6'h03;
  localparam logic [5:0] A_LINE  = 6'h04;
  localparam logic [5:0] A_BKRES = 6'h05;
  localparam logic [5:0] A_ISTAT = 6'h06;
  localparam logic [5:0] A_ICLR  = 6'h07;
  localparam logic [5:0] A_IEN   = 6'h08;
  localparam logic [5:0] A_STAT  = 6'h09;

  // Control register fields.
  localparam int C_DONE = 0;
  localparam int C_MODE = 1;   // Two bits.
  localparam int C_ESTOP = 3;
  localparam int C_DOOR = 4;
  localparam int C_READY = 5;
  localparam int C_RUN = 6;
  localparam int C_PAUSE = 7;
  localparam int C_BKBUSY = 8;
  localparam int C_RECOV = 9;
  localparam int C_ACDROP = 10;
  localparam int C_SWSD = 11;
  localparam int C_RERR = 12;
  localparam int C_DUST = 13;  // Two bits.
  localparam int NUM_ACT = 16; // Active bit of error and warning words.
  localparam int LN_TASK = 16; // Task index field of the line word.
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [3:0]  TASK_RST = 4'h1;

  // Interrupt bits.
  localparam int IRQ_OK = 0;
  localparam int IRQ_FAIL = 1;
  localparam int IRQ_END = 2;

  // Particular status codes.
  localparam logic [15:0] CODE_RECOV = 16'h9999;
  localparam logic [15:0] CODE_ACDROP = 16'h9998;
  localparam logic [15:0] CODE_SWSD = 16'h9997;

  // Default glyphs, segments gfedcba, leftmost digit in the top bits.
  localparam logic [27:0] GLY_BKA   = {7'h7C, 7'h77, 7'h40, 7'h40};
  localparam logic [27:0] GLY_BKB   = {7'h40, 7'h40, 7'h7C, 7'h77};
  localparam logic [27:0] GLY_OK    = {7'h7C, 7'h5C, 7'h5C, 7'h00};
  localparam logic [27:0] GLY_FAIL  = {7'h7C, 7'h79, 7'h79, 7'h00};
  localparam logic [27:0] GLY_ERR   = {7'h79, 7'h50, 7'h50, 7'h00};
  localparam logic [27:0] GLY_WARN  = {7'h40, 7'h77, 7'h40, 7'h00};
  localparam logic [27:0] GLY_ESTOP = {7'h79, 7'h6D, 7'h40, 7'h40};
  localparam logic [27:0] GLY_DOOR  = {7'h5E, 7'h50, 7'h40, 7'h40};
  localparam logic [27:0] GLY_READY = {7'h50, 7'h5E, 7'h6E, 7'h00};
  localparam logic [6:0]  PFX_RUN   = 7'h79;
  localparam logic [6:0]  PFX_PAUSE = 7'h73;

  typedef enum logic [1:0] {
    MODE_TEST = 2'b00, MODE_TEACH = 2'b01, MODE_AUTO = 2'b10, MODE_PROG = 2'b11
  } sid_mode_e;

  typedef enum logic [1:0] {
    DU_OFF = 2'b00, DU_POWER = 2'b01, DU_LINK = 2'b10, DU_NORMAL = 2'b11
  } sid_du_e;

  typedef enum logic [3:0] {
    SH_BLANK = 4'h0, SH_RECOV = 4'h1, SH_ACDROP = 4'h2, SH_SWSD = 4'h3,
    SH_BKBUSY = 4'h4, SH_BKOK = 4'h5, SH_BKFAIL = 4'h6, SH_ERR = 4'h7,
    SH_WARN = 4'h8, SH_ESTOP = 4'h9, SH_DOOR = 4'hA, SH_READY = 4'hB,
    SH_RUN = 4'hC, SH_PAUSE = 4'hD, SH_IDLE = 4'hE
  } sid_show_e;

  // Hex digit to segment pattern.
  function automatic logic [6:0] sid_seg7(input logic [3:0] h);
    logic [6:0] s;
    unique case (h)
      4'h0: s = 7'h3F;
      4'h1: s = 7'h06;
      4'h2: s = 7'h5B;
      4'h3: s = 7'h4F;
      4'h4: s = 7'h66;
      4'h5: s = 7'h6D;
      4'h6: s = 7'h7D;
      4'h7: s = 7'h07;
      4'h8: s = 7'h7F;
      4'h9: s = 7'h6F;
      4'hA: s = 7'h77;
      4'hB: s = 7'h7C;
      4'hC: s = 7'h39;
      4'hD: s = 7'h5E;
      4'hE: s = 7'h79;
      4'hF: s = 7'h71;
    endcase
    return s;
  endfunction : sid_seg7
endpackage : sid_pkg

//--- sid_du_if.sv
`timescale 1ns/1ps
// Control side to drive unit LED logic.
interface sid_du_if;
  import sid_pkg::*;
  logic    tick;
  sid_du_e st;
  logic    auto_mode;
  logic    robot_err;
  logic    estop;
  logic    run_led;
  logic    auto_led;
  logic    err_led;
  logic    link_led;
  modport ctl (output tick, st, auto_mode, robot_err, estop,
               input run_led, auto_led, err_led, link_led);
  modport drv (input tick, st, auto_mode, robot_err, estop,
               output run_led, auto_led, err_led, link_led);
endinterface : sid_du_if

//--- sid_drive_unit.sv
`timescale 1ns/1ps
module sid_drive_unit
  import sid_pkg::*;
#(
  parameter logic [11:0] SLOW_MS_P = SLOW_MS,
  parameter logic [11:0] FAST_MS_P = FAST_MS
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Status in, LEDs out.
  sid_du_if.drv    du
);
  logic [1:0] fl_q;

  // Two flash generators on the ms tick: index 0 slow, index 1 rapid.
  for (genvar gi = 0; gi < 2; gi++) begin : g_flash
    localparam logic [11:0] PER = (gi == 0) ? SLOW_MS_P : FAST_MS_P;
    logic [11:0] cnt_q;
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        cnt_q    <= 12'h000;
        fl_q[gi] <= 1'b0;
      end else if (du.tick) begin
        if (cnt_q >= PER - 12'h001) begin
          cnt_q    <= 12'h000;
          fl_q[gi] <= ~fl_q[gi];
        end else begin
          cnt_q <= cnt_q + 12'h001;
        end
      end
    end
  end

  // LEDs follow the startup state; mode and error only once connected.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      du.run_led  <= 1'b0;
      du.auto_led <= 1'b0;
      du.err_led  <= 1'b0;
      du.link_led <= 1'b0;
    end else begin
      unique case (du.st)
        DU_OFF: begin
          du.run_led  <= 1'b0;
          du.auto_led <= 1'b0;
          du.err_led  <= 1'b0;
          du.link_led <= 1'b0;
        end
        DU_POWER: begin
          du.run_led  <= fl_q[0];
          du.auto_led <= 1'b0;
          du.err_led  <= 1'b0;
          du.link_led <= 1'b0;
        end
        DU_LINK: begin
          du.run_led  <= fl_q[0];
          du.auto_led <= 1'b0;
          du.err_led  <= 1'b0;
          du.link_led <= fl_q[1];
        end
        DU_NORMAL: begin
          du.run_led  <= 1'b1;
          du.link_led <= fl_q[1];
          du.auto_led <= du.auto_mode;
          // Emergency stop outranks a robot error: steady beats flashing.
          du.err_led  <= du.estop | (du.robot_err & fl_q[0]);
        end
      endcase
    end
  end
endmodule : sid_drive_unit

//--- sid_chk.sv
`timescale 1ns/1ps
module sid_chk
  import sid_pkg::*;
#(
  parameter int          TICK_CYC_P = TICK_CYC,
  parameter logic [11:0] BLINK_MS_P = BLINK_MS,
  parameter logic [11:0] FAST_MS_P  = FAST_MS
) (
  // Clock and reset.
  input wire logic        clk_sys,
  input wire logic        rst_n,
  // Wishbone.
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Indicators.
  input wire logic [3:0]  mode_led,
  input wire logic [27:0] seg_out,
  input wire logic        du_run_led,
  input wire logic        du_auto_led,
  input wire logic        du_err_led,
  input wire logic        du_link_led,
  input wire logic        irq
);
  localparam int BLINK_WIN = int'(BLINK_MS_P) * TICK_CYC_P + TICK_CYC_P + 4;
  localparam int LINK_WIN  = int'(FAST_MS_P) * TICK_CYC_P + TICK_CYC_P + 4;
  logic [15:0] ctrl_q;
  logic [3:0]  calm_q;
  logic [31:0] mled_still_q;
  logic [31:0] link_still_q;
  wire         wr_ctrl = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i[7:2] == A_CTRL;
  wire         halt    = !rst_n || wr_ctrl;
  wire         calm    = calm_q > 4'h3;
  wire         done    = ctrl_q[C_DONE];
  wire [1:0]   ds      = ctrl_q[14:13];

  // Shadow of the control word, so outputs can be judged once they had time to follow it.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= 16'h0000;
      calm_q <= 4'h0;
    end else if (wr_ctrl) begin
      ctrl_q <= {wb_sel_i[1] ? wb_dat_i[15:8] : ctrl_q[15:8], wb_sel_i[0] ? wb_dat_i[7:0] : ctrl_q[7:0]};
      calm_q <= 4'h0;
    end else if (calm_q != 4'hF) begin
      calm_q <= calm_q + 4'h1;
    end
  end

  // Cycles since the mode LEDs and the link LED last moved; a long wait is counted, not unrolled.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mled_still_q <= 32'h0;
      link_still_q <= 32'h0;
    end else begin
      mled_still_q <= (halt || $changed(mode_led)) ? 32'h0 : mled_still_q + 32'h1;
      link_still_q <= (halt || $changed(du_link_led)) ? 32'h0 : link_still_q + 32'h1;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_take; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_ack1; wb_ack_o ##1 !wb_ack_o; endsequence

  a_ack_one_cycle: assert property (s_take |=> s_ack1) else $error("ack not a single pulse");
  a_boot_blank: assert property (calm && !done |-> seg_out == 28'h0)
    else $error("display lit before startup");
  a_boot_leds_same: assert property (calm && !done |-> mode_led == 4'h0 || mode_led == 4'hF)
    else $error("mode leds not together");
  a_boot_leds_blink: assert property (calm && !done |-> mled_still_q < BLINK_WIN)
    else $error("mode leds not blinking");
  a_mode_led_one: assert property (calm && done |-> mode_led == 4'(4'h1 << ctrl_q[2:1]))
    else $error("wrong mode led");
  a_code_recovery: assert property (calm && done && ctrl_q[C_RECOV] |-> seg_out == {4{7'h6F}})
    else $error("recovery code missing");
  a_code_ac_drop: assert property (calm && done && ctrl_q[10:9] == 2'b10 |-> seg_out == {7'h6F, 7'h6F, 7'h6F, 7'h7F})
    else $error("supply drop code missing");
  a_code_sw_down: assert property (calm && done && ctrl_q[11:9] == 3'b100 |-> seg_out == {7'h6F, 7'h6F, 7'h6F, 7'h07})
    else $error("shutdown code missing");
  a_du_off_dark: assert property (calm && ds == 2'b00 |-> !(du_run_led || du_auto_led || du_err_led || du_link_led))
    else $error("drive leds lit while off");
  a_du_normal_leds: assert property (calm && ds == 2'b11 |-> du_run_led && du_auto_led == (ctrl_q[2:1] == 2'b10))
    else $error("drive run or auto led wrong");
  a_du_estop_steady: assert property (calm && ds == 2'b11 && ctrl_q[C_ESTOP] |-> du_err_led)
    else $error("stop led not steady");
  a_link_flashing: assert property (calm_q == 4'hF && ds[1] |-> link_still_q < LINK_WIN)
    else $error("link led not flashing");
endmodule : sid_chk

bind sid_status_top sid_chk #(.TICK_CYC_P(TICK_CYC_P), .BLINK_MS_P(BLINK_MS_P), .FAST_MS_P(FAST_MS_P)) sid_chk_i (
  .clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .mode_led(mode_led), .seg_out(seg_out), .du_run_led(du_run_led),
  .du_auto_led(du_auto_led), .du_err_led(du_err_led), .du_link_led(du_link_led), .irq(irq));

//--- sid_led_model.sv
`timescale 1ns/1ps
module sid_led_model (
  // Segments as the viewer sees them.
  input  wire logic [27:0] seg_out,
  // Numerals read off the four digits, F where a digit shows no numeral.
  output logic      [15:0] digits
);
  localparam logic [6:0] NUM [10] = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D, 7'h7D, 7'h07, 7'h7F, 7'h6F};

  // A glyph that matches no numeral reads as F, so it can never pass for a number.
  function automatic logic [3:0] dec(input logic [6:0] s);
    dec = 4'hF;
    for (int i = 0; i < 10; i++) if (s === NUM[i]) dec = 4'(i);
  endfunction : dec

  // Reading the glass, leftmost digit first.
  always_comb digits = {dec(seg_out[27:21]), dec(seg_out[20:14]), dec(seg_out[13:7]), dec(seg_out[6:0])};
endmodule : sid_led_model

//--- tb_status_indicator_display.sv
`timescale 1ns/1ps
module tb_status_indicator_display;
  import sid_pkg::*;
  logic        clk_sys = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, ack, irq, run, auto, err, link;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0, mode_led;
  logic [31:0] wdat = 32'h0, rdat, dat_o, c;
  logic [27:0] seg_out;
  logic [15:0] digits, e;
  logic [1:0]  m, ds;
  int          errors = 0, comparisons = 0, cycles = 0, seen;

  sid_status_top #(.TICK_CYC_P(10), .BLINK_MS_P(12'h004), .SLOW_MS_P(12'h008), .FAST_MS_P(12'h002))
    sid_status_top_i (.clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .mode_led(mode_led), .seg_out(seg_out), .du_run_led(run), .du_auto_led(auto),
    .du_err_led(err), .du_link_led(link), .irq(irq));
  sid_led_model sid_led_model_i (.seg_out(seg_out), .digits(digits));

  always #10 clk_sys = ~clk_sys;

  task automatic finish_test();
    if (errors == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test

  // The whole run needs about 32000 cycles, so this only trips on a hang.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 60000) begin
      errors++;
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] seen_v, input logic [31:0] exp);
    comparisons++;
    if (seen_v !== exp) begin
      errors++;
      $display("BAD t=%0t seen %h expected %h", $time, seen_v, exp);
    end
  endtask : chk

  // One classic cycle; the request stands until the rising edge that samples ack high.
  // No wait limit here: only the bench timeout ends a hung access.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= 4'hF;
    wdat <= d;
    do begin
      @(posedge clk_sys);
    end while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    @(posedge clk_sys);
  endtask : bus

  // Waits n cycles and leaves the caller at a falling edge, where outputs are settled.
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : settle

  // A blinking pattern must show exp while lit and nothing else.
  task automatic blink_chk(input logic [27:0] exp);
    seen = 0;
    repeat (100) begin
      @(negedge clk_sys);
      if (seg_out !== 28'h0) begin
        chk(32'(seg_out), 32'(exp));
        seen++;
      end
    end
    chk(32'(seen > 0 && seen < 100), 32'h1);
    @(posedge clk_sys);
  endtask : blink_chk

  initial begin
    void'($urandom(11));
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    bus(0, 8'h0C, 0); chk(rdat, 32'h1);
    bus(1, 8'h3C, 32'hFFFF_FFFF);
    bus(0, 8'h3C, 0); chk(rdat, 32'h0);
    seen = 0;
    repeat (60) begin
      @(negedge clk_sys);
      chk(32'(seg_out), 32'h0);
      if (mode_led === 4'hF) seen++;
    end
    chk(32'(seen > 0), 32'h1);
    @(posedge clk_sys);
    // Random mode, drive state, stop and robot error, held long enough for the link flash to show.
    repeat (10) begin
      m = 2'($urandom % 4);
      ds = 2'($urandom % 4);
      c = $urandom % 4;
      bus(1, 8'h00, (32'(ds) << 13) | (32'(c[1]) << 12) | (32'(c[0]) << 3)
                    | (32'(m) << 1) | 32'h1);
      settle(50);
      chk(32'(mode_led), 32'h1 << m);
      if (ds == 2'b11) chk(32'({run, auto}), 32'({1'b1, m == 2'b10}));
      if (ds == 2'b11 && (c[0] || !c[1])) chk(32'(err), 32'(c[0]));
      if (ds == 2'b01 || ds == 2'b10) chk(32'({auto, err}), 32'h0);
      if (ds == 2'b00) chk(32'({run, auto, err, link}), 32'h0);
      @(posedge clk_sys);
    end
    for (int i = 0; i < 3; i++) begin
      bus(1, 8'h00, 32'h19 | (32'hE00 & (32'hE00 << i)));
      settle(3);
      chk(32'(digits), 32'h9999 - 32'(i));
      @(posedge clk_sys);
    end
    e = {4'($urandom % 10), 4'($urandom % 10), 4'($urandom % 10), 4'($urandom % 10)};
    bus(1, 8'h04, {15'h0, 1'b1, e});
    bus(1, 8'h08, 32'h1_5678);
    bus(1, 8'h00, 32'h19);
    settle(3); chk(32'(digits), 32'(e));
    settle(5300); chk(32'(seg_out), 32'(GLY_ERR));
    @(posedge clk_sys);
    bus(1, 8'h04, 32'h0);
    settle(3); chk(32'(digits), 32'h5678);
    settle(5300); chk(32'(seg_out), 32'(GLY_WARN));
    @(posedge clk_sys);
    bus(1, 8'h08, 32'h0);
    blink_chk(GLY_ESTOP);
    bus(1, 8'h00, 32'h11);
    blink_chk(GLY_DOOR);
    bus(1, 8'h00, 32'h21);
    blink_chk(GLY_READY);
    bus(1, 8'h00, 32'h41);
    bus(1, 8'h10, 32'h0001_0123);
    blink_chk({PFX_RUN, 7'h06, 7'h5B, 7'h4F});
    bus(1, 8'h10, 32'h0002_0456);
    bus(1, 8'h0C, 32'h2);
    bus(0, 8'h10, 0); chk(rdat, 32'h0002_0456);
    blink_chk({PFX_RUN, 7'h66, 7'h6D, 7'h7D});
    bus(1, 8'h00, 32'h81);
    blink_chk({PFX_PAUSE, 7'h66, 7'h6D, 7'h7D});
    bus(1, 8'h00, 32'h181);
    settle(3);
    chk(32'(seg_out), 32'(GLY_BKA));
    @(posedge clk_sys);
    bus(1, 8'h00, 32'h41);
    bus(1, 8'h20, 32'h7);
    bus(1, 8'h14, 32'h2);
    settle(3);
    chk(32'({seg_out, irq}), 32'({GLY_FAIL, 1'b1}));
    settle(20200); chk(32'(seg_out === GLY_FAIL), 32'h0);
    @(posedge clk_sys);
    bus(0, 8'h18, 0); chk(rdat, 32'h6);
    bus(1, 8'h1C, 32'h7);
    bus(0, 8'h18, 0);
    chk(rdat, 32'h0);
    chk(32'(irq), 32'h0);
    bus(1, 8'h20, 32'h0);
    bus(1, 8'h14, 32'h1);
    settle(3);
    chk(32'({seg_out, irq}), 32'({GLY_OK, 1'b0}));
    @(posedge clk_sys);
    bus(0, 8'h18, 0); chk(rdat, 32'h1);
    finish_test();
  end
endmodule : tb_status_indicator_display
